//--- verilog/sbcspi_pkg.sv
// sbcspi_pkg: constants, register tables and carrier types of the spi register bank.
// assumes a single 125 MHz clock domain; spi pins are asynchronous to it.
`default_nettype none
package sbcspi_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // frame layout: bit 0 is shifted first, bits 0..6 address, bit 7 access, 8..15 data
    localparam int           NREG        = 22;
    localparam logic [4:0]   FRAME_BITS  = 5'h10;
    localparam logic [4:0]   ADDR_LAST   = 5'h07;   // last bit of the address byte
    localparam logic [4:0]   DATA_FIRST  = 5'h08;
    localparam logic [2:0]   SYNC_RST    = 3'h0;
    localparam logic [7:0]   BYTE_ZERO   = 8'h00;
    // mode field of mode_supply_control; value 11 asks for a soft reset
    localparam int           MODE_HI     = 7;
    localparam int           MODE_LO     = 6;
    localparam logic [1:0]   MODE_SOFT   = 2'h3;
    localparam int           MS_IDX      = 0;       // mode_supply_control
    localparam int           ID_IDX      = 21;      // family_product_ident

    ////////////////////////////////////////////////////////////////////////////////
    // per-register tables, index 0 first
    localparam logic [0:NREG-1][6:0] REG_ADDR = '{
        7'h01, 7'h04, 7'h05, 7'h07, 7'h08, 7'h0D, 7'h10, 7'h14, 7'h15, 7'h17, 7'h18,
        7'h19, 7'h1C, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h54, 7'h55, 7'h7E};
    // implemented bits; everything else is reserved and reads 0
    localparam logic [0:NREG-1][7:0] VALID_MASK = '{
        8'hFF, 8'hFF, 8'h23, 8'hA7, 8'h3F, 8'h77, 8'h70, 8'h77, 8'h77, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h5F, 8'hBF, 8'h07, 8'hCF, 8'h67, 8'h06, 8'h0F, 8'h0F, 8'hFF};
    // bits that device logic may rewrite (rwh)
    localparam logic [0:NREG-1][7:0] HW_MASK = '{
        8'hFC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // bits kept on restart (x); the others load RST_VAL
    localparam logic [0:NREG-1][7:0] RST_KEEP = '{
        8'h23, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0]   POR_VAL     = 8'h00;
    localparam logic [7:0]   RST_VAL     = 8'h00;
    // status registers: hardware sets, a write of 0 clears
    localparam logic [NREG-1:0] IS_STAT  = 22'h1FE000;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } sbcspi_pins_t;

    typedef struct packed {
        logic [7:0] data;   // frame bits 15..8
        logic       we;     // frame bit 7
        logic [6:0] addr;   // frame bits 6..0
    } sbcspi_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_HOLD
    } sbcspi_state_t;
endpackage
`default_nettype wire

//--- verilog/sbcspi_regbank.sv
// sbcspi_regbank: spi command decoder and register bank of the system basis chip.
// assumes an spi master using mode 1, lsb first; device logic drives restart and events.
//
// Contract
// - frame is 16 bits: address, mode, data
// - data bits d0..d7 are frame bits 8..15
// - bit 7 low reads, writes nothing
// - bit 7 high stores data byte
// - reserved bits read zero, master writes zero
// - reset and soft reset load reset values
// - restart loads restart value, x bits kept
// - bit types: r, rw, rwh honoured
// - device never alters plain control bits
// - one address selects one whole byte
// - write returns previously programmed contents
`default_nettype none
module sbcspi_regbank #(
    parameter logic [7:0] IDENT = 8'h5A   // arbitrary identification value
) (
    // clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    sys_rst,
    // spi pins
    input  wire sbcspi_pkg::sbcspi_pins_t                spi_i,
    output logic                                         miso_o,
    output logic                                         miso_oe,
    // device logic side
    input  wire logic                                    restart_i,
    input  wire logic [sbcspi_pkg::NREG-1:0]             hw_upd_en,
    input  wire logic [sbcspi_pkg::NREG-1:0][7:0]        hw_upd_val,
    input  wire logic [sbcspi_pkg::NREG-1:0][7:0]        stat_set,
    // register contents and frame events
    output logic [sbcspi_pkg::NREG-1:0][7:0]             regs_o,
    output logic                                         frame_done_o,
    output logic                                         frame_err_o,
    output logic                                         soft_reset_o
);
    localparam int N = sbcspi_pkg::NREG;

    // every check below runs on the one system clock and sleeps through reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // one-hot register select for an address; all zero when unmapped
    function automatic logic [N-1:0] sel_of(input logic [6:0] a);
        logic [N-1:0] s;
        s = '0;
        for (int i = 0; i < N; i++) begin
            s[i] = (a == sbcspi_pkg::REG_ADDR[i]);
        end
        return s;
    endfunction

    // read multiplexer; reserved bits masked, unmapped gives zero
    function automatic logic [7:0] read_of(input logic [6:0] a, input logic [N-1:0][7:0] r);
        logic [7:0]   v;
        logic [N-1:0] s;
        v = sbcspi_pkg::BYTE_ZERO;
        s = sel_of(a);
        for (int i = 0; i < N; i++) begin
            if (s[i]) begin
                v = r[i] & sbcspi_pkg::VALID_MASK[i];
            end
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage 0 feeds stage 1 only; a level counts once 1 and 2 agree
    logic [2:0] sclk_s_q;
    logic [2:0] cs_s_q;
    logic [2:0] mosi_s_q;
    logic       sclk_f_q;
    logic       cs_f_q;
    logic       sclk_fall;
    logic       sclk_rise;
    logic       cs_fall;
    logic       cs_rise;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_s_q <= sbcspi_pkg::SYNC_RST;
            cs_s_q   <= ~sbcspi_pkg::SYNC_RST;
            mosi_s_q <= sbcspi_pkg::SYNC_RST;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], spi_i.sclk};
            cs_s_q   <= {cs_s_q[1:0], spi_i.cs_n};
            mosi_s_q <= {mosi_s_q[1:0], spi_i.mosi};
        end
    end

    // filtered levels; a single-cycle glitch never reaches them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_f_q <= 1'b0;
            cs_f_q   <= 1'b1;
        end else begin
            if (sclk_s_q[2] == sclk_s_q[1]) begin
                sclk_f_q <= sclk_s_q[2];
            end
            if (cs_s_q[2] == cs_s_q[1]) begin
                cs_f_q <= cs_s_q[2];
            end
        end
    end

    assign sclk_fall = sclk_f_q && (sclk_s_q[2] == sclk_s_q[1]) && !sclk_s_q[2];
    assign sclk_rise = !sclk_f_q && (sclk_s_q[2] == sclk_s_q[1]) && sclk_s_q[2];
    assign cs_fall   = cs_f_q && (cs_s_q[2] == cs_s_q[1]) && !cs_s_q[2];
    assign cs_rise   = !cs_f_q && (cs_s_q[2] == cs_s_q[1]) && cs_s_q[2];

    ////////////////////////////////////////////////////////////////////////////////
    // frame shifter: sample mosi on falling sclk, lsb first
    sbcspi_pkg::sbcspi_state_t st_q;
    logic [4:0]                cnt_q;
    logic [15:0]               shreg_q;
    sbcspi_pkg::sbcspi_cmd_t   cmd_q;
    logic                      commit_q;
    logic                      capture;

    assign capture = (st_q == sbcspi_pkg::ST_SHIFT) && sclk_fall
                     && (cnt_q == sbcspi_pkg::ADDR_LAST);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q    <= sbcspi_pkg::ST_IDLE;
            cnt_q   <= '0;
            shreg_q <= '0;
        end else begin
            case (st_q)
                sbcspi_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        st_q  <= sbcspi_pkg::ST_SHIFT;
                        cnt_q <= '0;
                    end
                end
                sbcspi_pkg::ST_SHIFT: begin
                    if (cs_rise) begin
                        st_q <= sbcspi_pkg::ST_IDLE;
                    end else if (sclk_fall) begin
                        shreg_q[cnt_q[3:0]] <= mosi_s_q[2];
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == sbcspi_pkg::FRAME_BITS - 5'h01) begin
                            st_q <= sbcspi_pkg::ST_HOLD;
                        end
                    end
                end
                sbcspi_pkg::ST_HOLD: begin
                    // extra clocks after 16 bits are ignored; the frame is then too long
                    if (cs_rise) begin
                        st_q <= sbcspi_pkg::ST_IDLE;
                    end else if (sclk_fall) begin
                        cnt_q <= sbcspi_pkg::FRAME_BITS + 5'h01;
                    end
                end
                default: begin
                    st_q <= sbcspi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // end of frame: exactly 16 bits commit, anything else is dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            commit_q     <= 1'b0;
            frame_done_o <= 1'b0;
            frame_err_o  <= 1'b0;
            cmd_q        <= '0;
        end else begin
            commit_q     <= 1'b0;
            frame_done_o <= 1'b0;
            frame_err_o  <= 1'b0;
            if (st_q != sbcspi_pkg::ST_IDLE && cs_rise) begin
                if (cnt_q == sbcspi_pkg::FRAME_BITS) begin
                    commit_q     <= 1'b1;
                    frame_done_o <= 1'b1;
                    cmd_q        <= sbcspi_pkg::sbcspi_cmd_t'(shreg_q);
                end else begin
                    frame_err_o  <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // answer: contents caught once the address is in, before any write lands
    logic [7:0] tx_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_q <= sbcspi_pkg::BYTE_ZERO;
        end else if (capture) begin
            tx_q <= read_of(shreg_q[6:0], regs_o);
        end
    end

    // miso changes on rising sclk; first byte answers zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            miso_o  <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= (st_q != sbcspi_pkg::ST_IDLE) && !cs_rise;
            if (cs_fall) begin
                miso_o <= 1'b0;
            end else if (sclk_rise && st_q == sbcspi_pkg::ST_SHIFT) begin
                miso_o <= cnt_q[3] ? tx_q[cnt_q[2:0]] : 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // soft reset request: mode field written as 11
    logic [N-1:0] cmd_sel;
    logic         soft_req;

    assign cmd_sel  = commit_q ? sel_of(cmd_q.addr) : '0;
    assign soft_req = cmd_sel[sbcspi_pkg::MS_IDX] && cmd_q.we
                      && cmd_q.data[sbcspi_pkg::MODE_HI:sbcspi_pkg::MODE_LO]
                         == sbcspi_pkg::MODE_SOFT;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            soft_reset_o <= 1'b0;
        end else begin
            soft_reset_o <= soft_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register bank, one flop byte per address
    logic [N-1:0][7:0] reg_q;
    logic [N-1:0][7:0] reg_d;

    assign regs_o = reg_q;

    for (genvar g = 0; g < N; g++) begin : g_reg
        localparam logic [7:0] VM = sbcspi_pkg::VALID_MASK[g];
        localparam logic [7:0] HM = sbcspi_pkg::HW_MASK[g];
        localparam logic [7:0] KM = sbcspi_pkg::RST_KEEP[g];

        // next value: spi write, then device updates; an event beats a clear
        always_comb begin
            reg_d[g] = reg_q[g];
            if (g == sbcspi_pkg::ID_IDX) begin
                reg_d[g] = IDENT;
            end else if (sbcspi_pkg::IS_STAT[g]) begin
                if (cmd_sel[g] && cmd_q.we) begin
                    reg_d[g] = reg_q[g] & cmd_q.data;
                end
                reg_d[g] = (reg_d[g] | stat_set[g]) & VM;
            end else begin
                if (cmd_sel[g] && cmd_q.we && !soft_req) begin
                    reg_d[g] = cmd_q.data & VM;
                end
                if (hw_upd_en[g]) begin
                    reg_d[g] = (reg_d[g] & ~HM) | (hw_upd_val[g] & HM);
                end
            end
        end

        always_ff @(posedge clk) begin
            if (sys_rst || soft_reset_o) begin
                reg_q[g] <= (g == sbcspi_pkg::ID_IDX) ? IDENT : sbcspi_pkg::POR_VAL;
            end else if (restart_i) begin
                reg_q[g] <= ((reg_q[g] & KM) | (sbcspi_pkg::RST_VAL & ~KM)) & VM;
            end else begin
                reg_q[g] <= reg_d[g];
            end
        end

        a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
            (reg_q[g] & ~VM) == 8'h00)
            else $error("reserved bit set");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    logic quiet;
    assign quiet = !restart_i && !soft_reset_o;

    a_ident_fixed: assert property (regs_o[sbcspi_pkg::ID_IDX] == IDENT)
        else $error("ident register changed");

    a_read_nowrite: assert property (commit_q && !cmd_q.we && quiet |=> $stable(reg_q[1]))
        else $error("read frame altered a register");

    a_write_store: assert property (commit_q && cmd_q.we && cmd_sel[1] && quiet
        |=> reg_q[1] == $past(cmd_q.data))
        else $error("write did not store data byte");

    a_soft_por: assert property (soft_req ##1 1 |=> reg_q[sbcspi_pkg::MS_IDX] == 8'h00
        && reg_q[1] == 8'h00)
        else $error("soft reset did not load reset values");

    a_restart_keep: assert property (restart_i && !soft_reset_o
        |=> reg_q[sbcspi_pkg::MS_IDX] == ($past(reg_q[sbcspi_pkg::MS_IDX]) & 8'h23))
        else $error("restart value wrong");

    a_ctrl_hold: assert property (!commit_q && quiet |=> $stable(reg_q[1]))
        else $error("control byte changed without a write");

    a_unmapped_zero: assert property (capture && sel_of(shreg_q[6:0]) == '0
        |=> tx_q == 8'h00)
        else $error("unmapped read not zero");

    a_answer_old: assert property (commit_q && cmd_q.we && cmd_sel[1]
        |-> tx_q == reg_q[1])
        else $error("answer is not the previous contents");

    a_frame_len: assert property (st_q != sbcspi_pkg::ST_IDLE && cs_rise
        && cnt_q != sbcspi_pkg::FRAME_BITS
        |=> frame_err_o && !frame_done_o && !commit_q ##1 !commit_q)
        else $error("short or long frame committed");

    a_first_data: assert property (sclk_rise && st_q == sbcspi_pkg::ST_SHIFT
        && cnt_q == sbcspi_pkg::DATA_FIRST |=> miso_o == tx_q[0])
        else $error("d0 not on frame bit 8");

    a_event_wins: assert property (quiet && (stat_set[13] & 8'h5F) != 8'h00
        |=> (reg_q[13] & $past(stat_set[13]) & 8'h5F) == ($past(stat_set[13]) & 8'h5F))
        else $error("status event lost");

    c_write_frame: cover property (commit_q && cmd_q.we);
    c_read_frame:  cover property (commit_q && !cmd_q.we);
    c_soft_reset:  cover property (soft_reset_o);
    c_restart:     cover property (restart_i ##[1:600] frame_done_o);
endmodule // sbcspi_regbank
`default_nettype wire

//--- verification/sbcspi_master.sv
// sbcspi_master: behavioural spi master standing in for the microcontroller.
// assumes the bench clock at 125 MHz; mode 1, lsb first, pins change at falling clk.
`default_nettype none
module sbcspi_master (
    // clock
    input  wire logic                clk,
    // spi pins
    output sbcspi_pkg::sbcspi_pins_t pins,
    input  wire logic                miso,
    input  wire logic                miso_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // idle: clock low, select high; data line toggles so stale values never pass
    initial begin
        pins = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    end

    // one frame; phases of 6 clk keep above the 2 clk filter minimum
    task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [7:0] rd);
        logic [15:0] rx;
        rx = 16'h0000;
        @(negedge clk);
        pins.cs_n = 1'b0;
        repeat (6) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            pins.sclk = 1'b1;
            pins.mosi = cmd[i % 16];
            repeat (6) @(negedge clk);
            // a floating answer line must not read as data
            rx[i % 16] = miso_oe ? miso : 1'bx;
            pins.sclk = 1'b0;
            repeat (6) @(negedge clk);
        end
        pins.cs_n = 1'b1;
        pins.mosi = ~pins.mosi;
        // gap well above 2 clk, and long enough for the commit to land
        repeat (10) @(negedge clk);
        rd = rx[15:8];
    endtask
endmodule // sbcspi_master
`default_nettype wire

//--- verification/sbcspi_regbank_tb.sv
// sbcspi_regbank_tb: self-checking bench for the spi register bank.
// assumes sbcspi_master drives the pins; device side inputs are driven here.
`default_nettype none
module sbcspi_regbank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                                 clk;
    logic                                 sys_rst;
    sbcspi_pkg::sbcspi_pins_t             spi;
    logic                                 miso;
    logic                                 miso_oe;
    logic                                 restart;
    logic [sbcspi_pkg::NREG-1:0]          hw_upd_en;
    logic [sbcspi_pkg::NREG-1:0][7:0]     hw_upd_val;
    logic [sbcspi_pkg::NREG-1:0][7:0]     stat_set;
    logic [sbcspi_pkg::NREG-1:0][7:0]     regs;
    logic                                 frame_done;
    logic                                 frame_err;
    logic                                 soft_reset;
    int                                   miscompares;
    int                                   samples_checked;
    int                                   done_cnt = 0;
    int                                   err_cnt = 0;
    int                                   soft_cnt = 0;
    logic [7:0]                           rd;

    sbcspi_regbank dut (.clk(clk), .sys_rst(sys_rst), .spi_i(spi), .miso_o(miso),
        .miso_oe(miso_oe), .restart_i(restart), .hw_upd_en(hw_upd_en),
        .hw_upd_val(hw_upd_val), .stat_set(stat_set), .regs_o(regs),
        .frame_done_o(frame_done), .frame_err_o(frame_err), .soft_reset_o(soft_reset));

    sbcspi_master mst (.clk(clk), .pins(spi), .miso(miso), .miso_oe(miso_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and event counters
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        done_cnt <= done_cnt + (frame_done === 1'b1);
        err_cnt  <= err_cnt + (frame_err === 1'b1);
        soft_cnt <= soft_cnt + (soft_reset === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic [7:0] old);
        mst.xfer({d, 1'b1, a}, 16, old);
    endtask

    task automatic rdr(input logic [6:0] a, output logic [7:0] v);
        mst.xfer({8'hFF, 1'b0, a}, 16, v); // data byte of a read is ignored
    endtask

    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < sbcspi_pkg::NREG; i++) begin
            chk("reset", (i == 21) ? 8'h5A : 8'h00, regs[i]);
        end
    endtask

    task automatic t_write_read;
        wr(7'h04, 8'h5A, rd);
        chk("old_on_write", 8'h00, rd);
        chk("regs1", 8'h5A, regs[1]);
        rdr(7'h04, rd);
        chk("read_back", 8'h5A, rd);
        chk("regs1_kept", 8'h5A, regs[1]);
        wr(7'h04, 8'hA5, rd);
        chk("old_second", 8'h5A, rd);
        chk("done_cnt", 8'h03, 8'(done_cnt));
        chk("neighbour", 8'h00, regs[2]);
    endtask

    task automatic t_reserved;
        wr(7'h05, 8'hFF, rd);
        rdr(7'h05, rd);
        chk("reserved", 8'h23, rd);
        wr(7'h7E, 8'h00, rd);
        chk("ident_read", 8'h5A, rd);
        chk("ident_kept", 8'h5A, regs[21]);
    endtask

    task automatic t_unmapped;
        wr(7'h02, 8'hFF, rd);
        chk("unmapped_old", 8'h00, rd);
        rdr(7'h02, rd);
        chk("unmapped_read", 8'h00, rd);
        for (int i = 0; i < 21; i++) begin
            chk("unmapped_state", (i == 1) ? 8'hA5 : (i == 2) ? 8'h23 : 8'h00, regs[i]);
        end
    endtask

    task automatic t_short;
        mst.xfer({8'h77, 1'b1, 7'h04}, 15, rd);
        chk("short_err", 8'h01, 8'(err_cnt));
        chk("short_kept", 8'hA5, regs[1]);
        // one clock too many must be refused just like one too few
        mst.xfer({8'h77, 1'b1, 7'h04}, 17, rd);
        chk("long_err", 8'h02, 8'(err_cnt));
        chk("long_kept", 8'hA5, regs[1]);
        chk("no_commit", 8'h08, 8'(done_cnt));
    endtask

    task automatic t_hw_restart;
        wr(7'h01, 8'h3F, rd);
        @(negedge clk);
        hw_upd_en[0]  = 1'b1;
        hw_upd_val[0] = 8'hA8;
        @(negedge clk);
        hw_upd_en[0]  = 1'b0;
        @(negedge clk);
        chk("hw_update", 8'hAB, regs[0]);
        chk("ctrl_untouched", 8'hA5, regs[1]);
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        repeat (2) @(negedge clk);
        chk("restart_mode", 8'h23, regs[0]);
        chk("restart_keep", 8'hA5, regs[1]);
    endtask

    task automatic t_status;
        @(negedge clk);
        stat_set[13] = 8'hFF;
        @(negedge clk);
        stat_set[13] = 8'h00;
        repeat (2) @(negedge clk);
        chk("stat_sticky", 8'h5F, regs[13]);
        wr(7'h40, 8'hFE, rd);
        chk("stat_old", 8'h5F, rd);
        chk("stat_clear", 8'h5E, regs[13]);
    endtask

    task automatic t_soft;
        wr(7'h01, 8'hC0, rd);
        chk("soft_pulse", 8'h01, 8'(soft_cnt));
        chk("soft_regs1", 8'h00, regs[1]);
        chk("soft_regs0", 8'h00, regs[0]);
        chk("soft_ident", 8'h5A, regs[21]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        miscompares = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        restart = 1'b0;
        hw_upd_en = '0;
        hw_upd_val = '0;
        stat_set = '0;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        t_reset();
        t_write_read();
        t_reserved();
        t_unmapped();
        t_short();
        t_hw_restart();
        t_status();
        t_soft();
        close_out();
    end

    // 13 frames of about 210 clk each; allow several times that
    initial begin
        #200000;
        miscompares++;
        close_out();
    end
endmodule // sbcspi_regbank_tb
`default_nettype wire
